/* File: design/wpmg_pkg.sv */
// Constants, register map and types of the watchdog programming-mode gate
package wpmg_pkg;
    // Clock and watchdog timing
    localparam int unsigned CLK_FREQ_MHZ  = 25;
    localparam int unsigned WDG_PERIOD_US = 2000;
    localparam int unsigned WDG_CYCLES    = WDG_PERIOD_US * CLK_FREQ_MHZ;

    // Register byte addresses
    localparam logic [7:0] ADDR_OPTION = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ    = 8'h0C;
    localparam logic [7:0] ADDR_CCR    = 8'h10;

    // Register indices
    localparam logic [2:0] IDX_OPTION = 3'h0;
    localparam logic [2:0] IDX_CTRL   = 3'h1;
    localparam logic [2:0] IDX_STATUS = 3'h2;
    localparam logic [2:0] IDX_IRQ    = 3'h3;
    localparam logic [2:0] IDX_CCR    = 3'h4;
    localparam logic [2:0] IDX_NONE   = 3'h7;

    // Field positions
    localparam int unsigned OPT_WDG_SW_SELECT_BIT = 0;
    localparam int unsigned CTRL_SW_EN_BIT        = 0;
    localparam int unsigned CTRL_REFRESH_BIT      = 1;
    localparam int unsigned IRQ_FLAG_BIT          = 0;
    localparam int unsigned IRQ_EN_BIT            = 1;
    localparam int unsigned IRQ_COLL_BIT          = 2;
    localparam int unsigned CCR_IMASK_BIT         = 3;

    // Reset values
    localparam logic [7:0] OPT_RESET = 8'hFF;
    localparam logic [7:0] CCR_RESET = 8'h08;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_COMM,
        MODE_PROG
    } wpmg_mode_t;
endpackage : wpmg_pkg

/* File: design/wpmg_if.sv */
// Link between the gate logic and the watchdog counter
`timescale 1ns/1ns
`default_nettype none
interface wpmg_if;
    logic enable;
    logic refresh;
    logic resetReq;
    modport main (output enable, output refresh, input resetReq);
    modport wdt  (input enable, input refresh, output resetReq);
endinterface : wpmg_if
`default_nettype wire

/* File: design/wpmg_wdt.sv */
// Watchdog counter that raises an internal reset request on timeout
`timescale 1ns/1ns
`default_nettype none
module wpmg_wdt #(
    parameter int unsigned CYCLES = wpmg_pkg::WDG_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control link
    wpmg_if.wdt       link
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count;

    // Timeout counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count         <= '0;
            link.resetReq <= 1'b0;
        end else begin
            link.resetReq <= 1'b0;
            if (!link.enable || link.refresh) begin
                count <= '0;
            end else if (count == LAST) begin
                count         <= '0;
                link.resetReq <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    property p_timeout;
        @(posedge clk) disable iff (!arst_n)
        link.enable && !link.refresh && count == LAST |=> link.resetReq;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout without reset request");

    property p_no_early;
        @(posedge clk) disable iff (!arst_n)
        link.resetReq |-> $past(count) == LAST && $past(link.enable);
    endproperty
    a_no_early: assert property (p_no_early) else $error("reset request before timeout");
endmodule : wpmg_wdt
`default_nettype wire

/* File: design/wpmg_top.sv */
// Watchdog gating for programming modes, interrupt clear guard, register slave
// Summary of operation
// - Option select bit zero means hardware watchdog
// - Communication mode never stops hardware watchdog resets
// - Option byte resets to software watchdog selected
// - Option-ignore mode ignores options, uses external clock
// - Clear colliding with request is caught safely
// - Condition code register never altered by clears
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module wpmg_top #(
    parameter int unsigned WDG_CYCLES = wpmg_pkg::WDG_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Tool pins
    input  wire logic        inCircuitCommMode,
    input  wire logic        optionIgnoreProgMode,
    input  wire logic        progClk,
    // Core side
    input  wire logic        irqReq,
    input  wire logic        inIsr,
    output logic             wdgResetReq,
    output logic             irqOut
);
    wpmg_if wdtLink ();

    wpmg_wdt #(.CYCLES(WDG_CYCLES)) u_wdt (
        .clk    (clk),
        .arst_n (arst_n),
        .link   (wdtLink.wdt)
    );

    function automatic logic [2:0] regIdx(input logic [7:0] a);
        case (a)
            wpmg_pkg::ADDR_OPTION: regIdx = wpmg_pkg::IDX_OPTION;
            wpmg_pkg::ADDR_CTRL:   regIdx = wpmg_pkg::IDX_CTRL;
            wpmg_pkg::ADDR_STATUS: regIdx = wpmg_pkg::IDX_STATUS;
            wpmg_pkg::ADDR_IRQ:    regIdx = wpmg_pkg::IDX_IRQ;
            wpmg_pkg::ADDR_CCR:    regIdx = wpmg_pkg::IDX_CCR;
            default:               regIdx = wpmg_pkg::IDX_NONE;
        endcase
    endfunction : regIdx

    logic [2:0]           syncA;
    logic [2:0]           syncB;
    logic                 progClkDly;
    logic                 progEdge;
    wpmg_pkg::wpmg_mode_t modeState;
    logic [7:0]           optionByte;
    logic                 swEnable;
    logic                 refresh;
    logic                 irqFlag;
    logic                 irqEn;
    logic                 collision;
    logic [7:0]           ccr;
    logic [7:0]           resetCount;
    logic [7:0]           stepCount;
    logic                 seenClk;
    logic                 wrFire;
    logic [2:0]           wrIdx;
    logic                 wrLow;
    logic                 hwActive;
    logic                 wdgEnable;
    logic                 flagClr;
    logic                 enClr;
    logic                 clrEvt;
    logic                 unsafe;

    // Pin synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA      <= 3'h0;
            syncB      <= 3'h0;
            progClkDly <= 1'b0;
        end else begin
            syncA      <= {progClk, optionIgnoreProgMode, inCircuitCommMode};
            syncB      <= syncA;
            progClkDly <= syncB[2];
        end
    end

    assign progEdge = syncB[2] && !progClkDly;

    // Mode tracking
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeState <= wpmg_pkg::MODE_NORMAL;
        end else begin
            case ({syncB[1], syncB[0]})
                2'b10, 2'b11: modeState <= wpmg_pkg::MODE_PROG;
                2'b01:        modeState <= wpmg_pkg::MODE_COMM;
                default:      modeState <= wpmg_pkg::MODE_NORMAL;
            endcase
        end
    end

    // Device steps follow the external clock in option-ignore mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stepCount <= 8'h00;
        end else if (modeState != wpmg_pkg::MODE_PROG || progEdge) begin
            stepCount <= stepCount + 8'h01;
        end
    end

    // Watchdog gating
    assign hwActive  = !optionByte[wpmg_pkg::OPT_WDG_SW_SELECT_BIT];
    assign wdgEnable = (modeState != wpmg_pkg::MODE_PROG)
                       && (hwActive || swEnable);
    assign wdtLink.enable  = wdgEnable;
    assign wdtLink.refresh = refresh;
    assign wdgResetReq     = wdtLink.resetReq;

    // Write channel
    assign wrFire        = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wrFire;
    assign s_axi_wready  = wrFire;
    assign wrIdx         = regIdx(s_axi_awaddr);
    assign wrLow         = wrFire && s_axi_wstrb[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= wpmg_pkg::RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrIdx == wpmg_pkg::IDX_NONE) ? wpmg_pkg::RESP_SLVERR
                                                           : wpmg_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Option byte and watchdog control
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            optionByte <= wpmg_pkg::OPT_RESET;
            swEnable   <= 1'b0;
            refresh    <= 1'b0;
        end else begin
            refresh <= wrLow && wrIdx == wpmg_pkg::IDX_CTRL
                       && s_axi_wdata[wpmg_pkg::CTRL_REFRESH_BIT];
            if (wrLow && wrIdx == wpmg_pkg::IDX_OPTION) begin
                optionByte <= s_axi_wdata[7:0];
            end
            if (wrLow && wrIdx == wpmg_pkg::IDX_CTRL) begin
                swEnable <= s_axi_wdata[wpmg_pkg::CTRL_SW_EN_BIT];
            end
        end
    end

    // Reset event counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resetCount <= 8'h00;
            seenClk    <= 1'b0;
        end else begin
            seenClk <= 1'b1;
            if (wdtLink.resetReq) begin
                resetCount <= resetCount + 8'h01;
            end
        end
    end

    // Interrupt flag, enable and clear guard
    assign flagClr = wrLow && wrIdx == wpmg_pkg::IDX_IRQ && s_axi_wdata[wpmg_pkg::IRQ_FLAG_BIT];
    assign enClr   = wrLow && wrIdx == wpmg_pkg::IDX_IRQ && irqEn
                     && !s_axi_wdata[wpmg_pkg::IRQ_EN_BIT];
    assign clrEvt  = flagClr || enClr;
    assign unsafe  = !inIsr && irqEn && !ccr[wpmg_pkg::CCR_IMASK_BIT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlag   <= 1'b0;
            irqEn     <= 1'b0;
            collision <= 1'b0;
            irqOut    <= 1'b0;
        end else begin
            irqFlag <= irqReq || (irqFlag && !flagClr);
            if (wrLow && wrIdx == wpmg_pkg::IDX_IRQ) begin
                irqEn <= s_axi_wdata[wpmg_pkg::IRQ_EN_BIT];
            end
            collision <= (irqReq && clrEvt && unsafe)
                         || (collision && !(wrLow && wrIdx == wpmg_pkg::IDX_IRQ
                                            && s_axi_wdata[wpmg_pkg::IRQ_COLL_BIT]));
            irqOut <= irqFlag && irqEn && !ccr[wpmg_pkg::CCR_IMASK_BIT];
        end
    end

    // Condition code register: only a direct write changes it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ccr <= wpmg_pkg::CCR_RESET;
        end else if (wrLow && wrIdx == wpmg_pkg::IDX_CCR) begin
            ccr <= s_axi_wdata[7:0];
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= wpmg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= wpmg_pkg::RESP_OKAY;
            case (regIdx(s_axi_araddr))
                wpmg_pkg::IDX_OPTION: s_axi_rdata <= {24'h000000, optionByte};
                wpmg_pkg::IDX_CTRL:   s_axi_rdata <= {31'h00000000, swEnable};
                wpmg_pkg::IDX_STATUS: s_axi_rdata <= {8'h00, stepCount, resetCount, 4'h0,
                                                      modeState == wpmg_pkg::MODE_COMM,
                                                      modeState == wpmg_pkg::MODE_PROG,
                                                      hwActive, wdgEnable};
                wpmg_pkg::IDX_IRQ:    s_axi_rdata <= {29'h00000000, collision, irqEn, irqFlag};
                wpmg_pkg::IDX_CCR:    s_axi_rdata <= {24'h000000, ccr};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= wpmg_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    sequence s_hw_comm;
        hwActive && modeState == wpmg_pkg::MODE_COMM;
    endsequence

    sequence s_unsafe_clear;
        irqReq && clrEvt && unsafe;
    endsequence

    property p_hw_active;
        @(posedge clk) disable iff (!arst_n)
        !optionByte[wpmg_pkg::OPT_WDG_SW_SELECT_BIT] && modeState != wpmg_pkg::MODE_PROG
            |-> wdgEnable;
    endproperty
    a_hw_active: assert property (p_hw_active) else $error("hardware watchdog not enabled");

    property p_comm_keeps;
        @(posedge clk) disable iff (!arst_n)
        s_hw_comm |-> wdtLink.enable;
    endproperty
    a_comm_keeps: assert property (p_comm_keeps) else $error("comm mode stopped watchdog");

    property p_factory;
        @(posedge clk) disable iff (!arst_n)
        !seenClk |-> optionByte[wpmg_pkg::OPT_WDG_SW_SELECT_BIT] && !wdgEnable;
    endproperty
    a_factory: assert property (p_factory) else $error("option not software select at reset");

    property p_prog_clock;
        @(posedge clk) disable iff (!arst_n)
        modeState == wpmg_pkg::MODE_PROG && !progEdge |=> $stable(stepCount);
    endproperty
    a_prog_clock: assert property (p_prog_clock) else $error("step without external edge");

    property p_collision;
        @(posedge clk) disable iff (!arst_n)
        s_unsafe_clear |=> collision && irqFlag;
    endproperty
    a_collision: assert property (p_collision) else $error("colliding clear lost");

    property p_ccr_intact;
        @(posedge clk) disable iff (!arst_n)
        clrEvt |=> $stable(ccr);
    endproperty
    a_ccr_intact: assert property (p_ccr_intact) else $error("condition codes altered");

    property p_prog_quiet;
        @(posedge clk) disable iff (!arst_n)
        (modeState == wpmg_pkg::MODE_PROG) [*2] |-> !wdtLink.enable && !wdgResetReq;
    endproperty
    a_prog_quiet: assert property (p_prog_quiet) else $error("watchdog active in prog mode");

    property p_irq_gate;
        @(posedge clk) disable iff (!arst_n)
        irqOut |-> $past(ccr[wpmg_pkg::CCR_IMASK_BIT]) == 1'b0 && $past(irqEn);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt passed global mask");
endmodule : wpmg_top
`default_nettype wire

/* File: sim/wpmg_tool_model.sv */
// Programming tool model: mode pins and external clock
`timescale 1ns/1ns
`default_nettype none
module wpmg_tool_model #(
    parameter bit HAS_IGNORE = 1'b1
) (
    // Tool pins
    output logic commPin,
    output logic progPin,
    output logic toolClk
);
    initial begin
        commPin = 1'b0;
        progPin = 1'b0;
        toolClk = 1'b0;
    end

    // Mode pins, changed just after a clock edge by the caller
    task automatic set_mode(input logic comm, input logic prog);
        commPin <= comm;
        progPin <= prog & HAS_IGNORE;
    endtask : set_mode

    // External clock only within a burst, idle low otherwise
    task automatic clock_burst(input int n);
        repeat (n) begin
            #150 toolClk = 1'b1;
            #160 toolClk = 1'b0;
            #10;
        end
    endtask : clock_burst
endmodule : wpmg_tool_model
`default_nettype wire

/* File: sim/testbench.sv */
// Register-level testbench of the watchdog programming-mode gate
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk;
    logic        arst_n;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid, s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid, s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid, s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid, s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid, s_axi_rready;
    logic        commPin, progPin, toolClk;
    logic        irqReq, inIsr, wdgResetReq, irqOut;
    int          n_errors, checks, nRst, nTot, cyc;
    logic [31:0] d;
    logic [31:0] stepA;
    logic [1:0]  rs;

    wpmg_top #(.WDG_CYCLES(20)) uut (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .inCircuitCommMode(commPin),
        .optionIgnoreProgMode(progPin), .progClk(toolClk),
        .irqReq(irqReq), .inIsr(inIsr), .wdgResetReq(wdgResetReq),
        .irqOut(irqOut)
    );

    wpmg_tool_model #(.HAS_IGNORE(1'b1)) tool (
        .commPin(commPin), .progPin(progPin), .toolClk(toolClk)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Watchdog pulses counted away from the launching edge
    always @(negedge clk) begin
        if (wdgResetReq === 1'b1) begin
            nRst++;
            nTot++;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        @(negedge clk);
        while (s_axi_awready !== 1'b1) @(negedge clk);
        @(posedge clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        @(negedge clk);
        while (s_axi_bvalid !== 1'b1) @(negedge clk);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, wpmg_pkg::RESP_OKAY});
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(negedge clk);
        while (s_axi_arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (s_axi_rvalid !== 1'b1) @(negedge clk);
        d  = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge clk);
    endtask : rd

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        rd(a);
        chk(nm, d & m, exp);
    endtask : rc

    initial begin
        arst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        irqReq = 1'b0;
        inIsr = 1'b0;
        n_errors = 0;
        checks = 0;
        nRst = 0;
        nTot = 0;
        cyc = 0;
        tick(3);
        arst_n <= 1'b1;
        tick(4);
        rc("option", wpmg_pkg::ADDR_OPTION, 32'hFFFFFFFF, 32'h000000FF);
        rc("ccr", wpmg_pkg::ADDR_CCR, 32'hFFFFFFFF, 32'h00000008);
        rc("status", wpmg_pkg::ADDR_STATUS, 32'h0000000F, 32'h0);
        rc("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
        chk("rresp", {30'h0, rs}, {30'h0, wpmg_pkg::RESP_SLVERR});
        // Software watchdog kept alive by refreshes, then left to expire
        wr(wpmg_pkg::ADDR_CTRL, 32'h00000001);
        rc("status sw", wpmg_pkg::ADDR_STATUS, 32'h0000000F, 32'h00000001);
        nRst = 0;
        repeat (10) begin
            wr(wpmg_pkg::ADDR_CTRL, 32'h00000003);
            tick(5);
        end
        chk("resets refreshed", nRst, 32'h0);
        tick(30);
        chk("sw timeout", 32'(nRst >= 1), 32'h1);
        wr(wpmg_pkg::ADDR_CTRL, 32'h00000000);
        // Hardware watchdog selected, then communication mode
        wr(wpmg_pkg::ADDR_OPTION, 32'h000000FE);
        tick(3);
        rc("status hw", wpmg_pkg::ADDR_STATUS, 32'h0000000F, 32'h00000003);
        tool.set_mode(1'b1, 1'b0);
        tick(4);
        nRst = 0;
        tick(100);
        chk("resets in comm", 32'(nRst >= 4), 32'h1);
        rc("status comm", wpmg_pkg::ADDR_STATUS, 32'h0000000F, 32'h0000000B);
        // Option-ignoring programming mode on the tool clock
        tool.set_mode(1'b1, 1'b1);
        tick(5);
        nRst = 0;
        rc("status prog", wpmg_pkg::ADDR_STATUS, 32'h0000000F, 32'h00000006);
        stepA = (d >> 16) & 32'hFF;
        tool.clock_burst(5);
        tick(5);
        rc("steps", wpmg_pkg::ADDR_STATUS, 32'h00FF0000, ((stepA + 32'h5) & 32'hFF) << 16);
        tick(100);
        chk("resets in prog", nRst, 32'h0);
        rc("reset count", wpmg_pkg::ADDR_STATUS, 32'h0000FF00, (nTot & 32'hFF) << 8);
        tool.set_mode(1'b0, 1'b0);
        // Interrupt clear colliding with a live request
        wr(wpmg_pkg::ADDR_CCR, 32'h0);
        wr(wpmg_pkg::ADDR_IRQ, 32'h00000002);
        irqReq <= 1'b1;
        tick(3);
        @(negedge clk);
        chk("irqOut", {31'h0, irqOut}, 32'h1);
        wr(wpmg_pkg::ADDR_IRQ, 32'h00000003);
        rc("irq coll", wpmg_pkg::ADDR_IRQ, 32'h7, 32'h7);
        rc("ccr coll", wpmg_pkg::ADDR_CCR, 32'hFF, 32'h0);
        irqReq <= 1'b0;
        wr(wpmg_pkg::ADDR_IRQ, 32'h00000007);
        rc("irq cleared", wpmg_pkg::ADDR_IRQ, 32'h7, 32'h2);
        inIsr <= 1'b1;
        irqReq <= 1'b1;
        wr(wpmg_pkg::ADDR_IRQ, 32'h00000003);
        rc("irq in isr", wpmg_pkg::ADDR_IRQ, 32'h7, 32'h3);
        inIsr <= 1'b0;
        // Clear bracketed by the global mask
        wr(wpmg_pkg::ADDR_CCR, 32'h00000008);
        tick(3);
        @(negedge clk);
        chk("irqOut masked", {31'h0, irqOut}, 32'h0);
        wr(wpmg_pkg::ADDR_IRQ, 32'h00000003);
        wr(wpmg_pkg::ADDR_CCR, 32'h0);
        rc("irq masked", wpmg_pkg::ADDR_IRQ, 32'h7, 32'h3);
        rc("ccr kept", wpmg_pkg::ADDR_CCR, 32'hFF, 32'h0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
